// ---- src/eight_bit_timer_pwm_output.sv ----
// Eight-bit timer with match-clear and PWM output modes, driving one port pin.
// Assumes a register master on clk_sys with one-cycle strobes and read data one cycle later.
//
// Behaviour
// - Mode 01000001B active high, 01000011B active low.
// - Selecting PWM mode leaves output flip-flop alone.
// - Run bit set starts counter, cleared halts it.
// - Output inactive after start until first overflow.
// - Overflow drives active level until compare match.
// - Match drives inactive until next overflow; repeats.
// - Clearing run bit makes output inactive immediately.
// - Period 256 count clocks, active width N.
// - Write before FFH edge applies next overflow.
// - Write after FFH edge applies second overflow.
// - Start is asynchronous to the count clock.
// - Counter reads come from an increment-updated buffer.
// - Mode bit 6 selects PWM, else match-clear.
// - Mode bit 0 gates the pulse output.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "pwm_timer_cfg.svh"

module eight_bit_timer_pwm_output #(
  parameter int DIV_W = 7
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`TMR_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic pulse_output_pin,
  output logic pulse_output_pin_oe
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  pwm_timer_pkg::mode_ctl_t timer_mode_control_q;
  pwm_timer_pkg::mode_ctl_t mode_wr;
  pwm_timer_pkg::pin_ctl_t pin_ctl_q;
  logic [`TMR_CLKSEL_W-1:0] count_clock_select_q;
  logic [7:0] eight_bit_counter_q;
  logic [7:0] eight_bit_counter_d;
  logic [7:0] read_buf_q;
  logic [7:0] duty_compare_value_q;
  logic [7:0] cmp_stage_q;
  logic [7:0] cmp_act_q;
  logic [7:0] cmp_next;
  logic [7:0] rdata_d;
  logic cmp_pend_q;
  logic cmp_armed_q;
  logic out_ff_q;
  logic out_level;
  logic count_tick;

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  function automatic logic reg_hit(input logic [`TMR_ADDR_W-1:0] a, input logic [`TMR_ADDR_W-1:0] off);
    return (a == off);
  endfunction : reg_hit

  logic wr_mode;
  logic wr_clksel;
  logic wr_cmp;
  logic wr_port;
  logic running;
  logic pwm_run;
  logic stop_req;
  logic tick_run;
  logic reach_top;
  logic overflow;
  logic clear_match;
  logic buffered_wr;

  assign mode_wr = pwm_timer_pkg::mode_ctl_t'(wdata);
  assign wr_mode = wr & reg_hit(addr, `TMR_OFF_MODE);
  assign wr_clksel = wr & reg_hit(addr, `TMR_OFF_CLKSEL);
  assign wr_cmp = wr & reg_hit(addr, `TMR_OFF_CMP);
  assign wr_port = wr & reg_hit(addr, `TMR_OFF_PORT);
  assign running = timer_mode_control_q.run;
  assign pwm_run = running & timer_mode_control_q.pwm;
  assign stop_req = wr_mode & ~mode_wr.run & running;
  assign tick_run = count_tick & running;
  assign reach_top = tick_run & timer_mode_control_q.pwm & (eight_bit_counter_q == `TMR_CNT_PRETOP);
  assign overflow = tick_run & timer_mode_control_q.pwm & (eight_bit_counter_q == `TMR_CNT_TOP);
  assign clear_match = tick_run & ~timer_mode_control_q.pwm & (eight_bit_counter_q == cmp_act_q);
  assign buffered_wr = wr_cmp & pwm_run;
  assign cmp_next = cmp_armed_q ? cmp_stage_q : cmp_act_q;

  // --------------------------------------------------------------------------
  // Count clock
  // --------------------------------------------------------------------------
  // The divider runs free of the run bit, so the first count edge after a
  // start may come up to one count period late.
  pwm_count_clock #(
    .DIV_W(DIV_W)
  ) u_count_clock (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .sel(count_clock_select_q),
    .tick(count_tick)
  );

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  // The level set and clear bits are write actions and are not stored.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      timer_mode_control_q <= pwm_timer_pkg::mode_ctl_t'(`TMR_MODE_RST);
    end
    else if (ce && wr_mode)
    begin
      timer_mode_control_q <= mode_wr;
      timer_mode_control_q.rsvd <= 2'h0;
      timer_mode_control_q.lvs <= 1'b0;
      timer_mode_control_q.lvr <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count_clock_select_q <= `TMR_CLKSEL_RST;
    end
    else if (ce && wr_clksel)
    begin
      count_clock_select_q <= wdata[`TMR_CLKSEL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pin_ctl_q.latch <= `TMR_LATCH_RST;
      pin_ctl_q.dir <= `TMR_DIR_RST;
    end
    else if (ce && wr_port)
    begin
      pin_ctl_q.latch <= wdata[`TMR_PORT_LATCH_BIT];
      pin_ctl_q.dir <= wdata[`TMR_PORT_DIR_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // Counter and read buffer
  // --------------------------------------------------------------------------
  always_comb
  begin
    if (clear_match)
    begin
      eight_bit_counter_d = `TMR_CNT_ZERO;
    end
    else
    begin
      eight_bit_counter_d = eight_bit_counter_q + `TMR_CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      eight_bit_counter_q <= `TMR_CNT_ZERO;
    end
    else if (ce)
    begin
      if (stop_req)
      begin
        eight_bit_counter_q <= `TMR_CNT_ZERO;
      end
      else if (tick_run)
      begin
        eight_bit_counter_q <= eight_bit_counter_d;
      end
    end
  end

  // Reads never stall the counter; a read in the increment cycle sees the old value.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      read_buf_q <= `TMR_CNT_ZERO;
    end
    else if (ce)
    begin
      if (stop_req)
      begin
        read_buf_q <= `TMR_CNT_ZERO;
      end
      else if (tick_run)
      begin
        read_buf_q <= eight_bit_counter_d;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Compare buffering
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      duty_compare_value_q <= `TMR_CMP_RST;
    end
    else if (ce && wr_cmp)
    begin
      duty_compare_value_q <= wdata;
    end
  end

  // A write in the cycle of the FFH edge counts as after it; the set wins.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cmp_pend_q <= 1'b0;
    end
    else if (ce)
    begin
      if (buffered_wr)
      begin
        cmp_pend_q <= 1'b1;
      end
      else if (reach_top || stop_req)
      begin
        cmp_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cmp_armed_q <= 1'b0;
      cmp_stage_q <= `TMR_CMP_RST;
    end
    else if (ce)
    begin
      if (stop_req)
      begin
        cmp_armed_q <= 1'b0;
      end
      else if (reach_top)
      begin
        cmp_armed_q <= cmp_pend_q;
        cmp_stage_q <= duty_compare_value_q;
      end
      else if (overflow)
      begin
        cmp_armed_q <= 1'b0;
      end
    end
  end

  // Outside a PWM run there is no overflow to wait for, so writes apply at once.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cmp_act_q <= `TMR_CMP_RST;
    end
    else if (ce)
    begin
      if (wr_cmp && !pwm_run)
      begin
        cmp_act_q <= wdata;
      end
      else if (stop_req)
      begin
        cmp_act_q <= duty_compare_value_q;
      end
      else if (overflow && cmp_armed_q)
      begin
        cmp_act_q <= cmp_stage_q;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Output flip-flop
  // --------------------------------------------------------------------------
  // In PWM mode the flip-flop holds active, not the pin level. A zero compare
  // never goes active, which keeps the output from staying active for the whole period.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      out_ff_q <= 1'b0;
    end
    else if (ce)
    begin
      if (stop_req && timer_mode_control_q.pwm)
      begin
        out_ff_q <= 1'b0;
      end
      else if (wr_mode && mode_wr.lvs && !mode_wr.lvr)
      begin
        out_ff_q <= 1'b0;
      end
      else if (wr_mode && mode_wr.lvr && !mode_wr.lvs)
      begin
        out_ff_q <= 1'b1;
      end
      else if (overflow)
      begin
        out_ff_q <= (cmp_next != `TMR_CNT_ZERO);
      end
      else if (tick_run && timer_mode_control_q.pwm && eight_bit_counter_d == cmp_act_q)
      begin
        // Clearing on the count edge that reaches N keeps the width at N ticks.
        out_ff_q <= 1'b0;
      end
      else if (clear_match && timer_mode_control_q.lvl)
      begin
        out_ff_q <= ~out_ff_q;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------------
  // The latch ORs onto the timer output, which is why it must be cleared first.
  always_comb
  begin
    if (timer_mode_control_q.pwm)
    begin
      out_level = out_ff_q ^ timer_mode_control_q.lvl;
    end
    else
    begin
      out_level = out_ff_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pulse_output_pin <= 1'b0;
      pulse_output_pin_oe <= 1'b0;
    end
    else if (ce)
    begin
      pulse_output_pin <= pin_ctl_q.latch | (timer_mode_control_q.gate & out_level);
      pulse_output_pin_oe <= ~pin_ctl_q.dir;
    end
  end

  // --------------------------------------------------------------------------
  // Register read
  // --------------------------------------------------------------------------
  always_comb
  begin
    rdata_d = `TMR_DATA_ZERO;
    if (reg_hit(addr, `TMR_OFF_MODE))
    begin
      rdata_d = timer_mode_control_q;
    end
    else if (reg_hit(addr, `TMR_OFF_CLKSEL))
    begin
      rdata_d = {5'h00, count_clock_select_q};
    end
    else if (reg_hit(addr, `TMR_OFF_CMP))
    begin
      rdata_d = duty_compare_value_q;
    end
    else if (reg_hit(addr, `TMR_OFF_CNT))
    begin
      rdata_d = read_buf_q;
    end
    else if (reg_hit(addr, `TMR_OFF_PORT))
    begin
      rdata_d = {6'h00, pin_ctl_q};
    end
  end

  // Read data stands only in the cycle after the strobe and is zero otherwise.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata <= `TMR_DATA_ZERO;
    end
    else if (ce)
    begin
      rdata <= rd ? rdata_d : `TMR_DATA_ZERO;
    end
  end

endmodule : eight_bit_timer_pwm_output

// ---- common/pwm_timer_cfg.svh ----
// Offsets, field positions, reset values and counter limits of the PWM timer.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PWM_TIMER_CFG_SVH
`define PWM_TIMER_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define TMR_ADDR_W 3
`define TMR_OFF_MODE 3'h0
`define TMR_OFF_CLKSEL 3'h1
`define TMR_OFF_CMP 3'h2
`define TMR_OFF_CNT 3'h3
`define TMR_OFF_PORT 3'h4

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TMR_PORT_LATCH_BIT 0
`define TMR_PORT_DIR_BIT 1
`define TMR_CLKSEL_W 3

// ----------------------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------------------
`define TMR_MODE_RST 8'h00
`define TMR_CLKSEL_RST 3'h0
`define TMR_CMP_RST 8'h00
`define TMR_CNT_ZERO 8'h00
`define TMR_CNT_ONE 8'h01
`define TMR_CNT_PRETOP 8'hfe
`define TMR_CNT_TOP 8'hff
`define TMR_DATA_ZERO 8'h00
`define TMR_LATCH_RST 1'b0
`define TMR_DIR_RST 1'b1

`endif

// ---- common/pwm_timer_pkg.sv ----
// Types shared by the PWM timer design files.
// Assumes pwm_timer_cfg.svh is on the include path.
`include "pwm_timer_cfg.svh"

package pwm_timer_pkg;

  // --------------------------------------------------------------------------
  // Mode control register layout, bit 7 down to bit 0
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic pwm;
    logic [1:0] rsvd;
    logic lvs;
    logic lvr;
    logic lvl;
    logic gate;
  } mode_ctl_t;

  // --------------------------------------------------------------------------
  // Pin control register layout
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic dir;
    logic latch;
  } pin_ctl_t;

endpackage : pwm_timer_pkg

// ---- src/pwm_count_clock.sv ----
// Count clock generator: one-cycle tick at clk_sys divided by two to the select.
// Assumes a free-running divider; the tick phase is unrelated to counter start.
`timescale 1ns/100ps
`include "pwm_timer_cfg.svh"

module pwm_count_clock #(
  parameter int DIV_W = 7
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`TMR_CLKSEL_W-1:0] sel,
  output logic tick
);

  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] mask;

  // --------------------------------------------------------------------------
  // Divider mask
  // --------------------------------------------------------------------------
  function automatic logic [DIV_W-1:0] sel_mask(input logic [`TMR_CLKSEL_W-1:0] s);
    logic [DIV_W-1:0] m;
    m = '0;
    for (int i = 0; i < DIV_W; i++)
    begin
      m[i] = (i < int'(s));
    end
    return m;
  endfunction : sel_mask

  assign mask = sel_mask(sel);

  // The divider never stops, so a start lands anywhere inside a count period.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      div_q <= '0;
    end
    else if (ce)
    begin
      div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tick <= 1'b0;
    end
    else if (ce)
    begin
      tick <= ((div_q & mask) == mask);
    end
  end

endmodule : pwm_count_clock

// ---- dv/pwm_timer_asserts.sv ----
// Checker for the PWM timer ports: register reads, pin enable and pulse level.
// Assumes one clock domain and a bind onto the top module.
`timescale 1ns/100ps
`include "pwm_timer_cfg.svh"

module pwm_timer_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`TMR_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic pulse_output_pin,
  input wire logic pulse_output_pin_oe
);
  logic [7:0] mode_q;
  logic latch_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Shadow of the mode byte and pin latch, so pin checks know the setup.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= 8'h00;
      latch_q <= 1'b0;
    end
    else if (ce && wr && addr == `TMR_OFF_MODE)
    begin
      mode_q <= wdata;
    end
    else if (ce && wr && addr == `TMR_OFF_PORT)
    begin
      latch_q <= wdata[0];
    end
  end

  sequence s_stop;
    mode_q[7:6] == 2'b11 && ce && wr && addr == `TMR_OFF_MODE && wdata[7:6] == 2'b01 && wdata[3:2] == 2'b00 && !latch_q;
  endsequence

  a_rdata_idle: assert property (ce && !rd |=> rdata == 8'h00) else $error("read data not idle");
  a_unmapped_read: assert property (ce && rd && addr > `TMR_OFF_PORT |=> rdata == 8'h00) else $error("unmapped read");
  a_mode_readback: assert property ((ce && wr && addr == `TMR_OFF_MODE) ##1 !wr ##1
    (ce && rd && addr == `TMR_OFF_MODE) |=> rdata == (mode_q & 8'hc3)) else $error("mode readback");
  a_cmp_readback: assert property ((ce && wr && addr == `TMR_OFF_CMP) ##1 !wr ##1
    (ce && rd && addr == `TMR_OFF_CMP) |=> rdata == $past(wdata, 3)) else $error("compare readback");
  a_oe_follows: assert property ((ce && wr && addr == `TMR_OFF_PORT) ##1 !wr
    |=> pulse_output_pin_oe == !$past(wdata[1], 2)) else $error("pin enable");
  a_gate_off: assert property ((!mode_q[0] && !latch_q) [*3] |-> !pulse_output_pin) else $error("gate");
  a_stop_inactive: assert property (s_stop |=> ##[1:2] pulse_output_pin == (mode_q[0] & mode_q[1]))
    else $error("stop level");
  a_cnt_stopped: assert property (s_stop ##[1:6] (ce && rd && addr == `TMR_OFF_CNT && !mode_q[7])
    |=> rdata == 8'h00) else $error("counter after stop");
endmodule : pwm_timer_asserts

bind eight_bit_timer_pwm_output pwm_timer_asserts i_chk (.clk_sys, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata,
  .pulse_output_pin, .pulse_output_pin_oe);

// ---- dv/test_eight_bit_timer_pwm_output.sv ----
// Self-checking bench for the PWM timer: register access and pulse shape.
// Assumes ce stays high and the checker is bound from its own file.
`timescale 1ns/100ps
`include "pwm_timer_cfg.svh"

module test_eight_bit_timer_pwm_output;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [`TMR_ADDR_W-1:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic pulse_output_pin;
  logic pulse_output_pin_oe;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'hbbe0;
  logic [7:0] n;
  logic pol;
  int err_count = 0;
  int checks_done = 0;
  int t0, w, g, k;

  eight_bit_timer_pwm_output i_dut (.clk_sys, .rst, .ce(1'b1), .addr, .wdata, .wr, .rd, .rdata,
    .pulse_output_pin, .pulse_output_pin_oe);

  always #2.5 clk_sys = ~clk_sys;

  // ----
  // Tasks
  // ----
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    checks_done++;
    if (seen !== expected)
    begin
      err_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic results();
    $display("checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // An idle edge follows each access, so a strobe is never set twice in one step.
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(posedge clk_sys);
  endtask : reg_rd

  task automatic wait_pin(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (pulse_output_pin !== lvl && cnt < lim)
    begin
      @(posedge clk_sys);
      cnt++;
    end
    if (cnt == lim)
    begin
      err_count++;
      results();
    end
  endtask : wait_pin

  task automatic measure(input logic act, output int rise, output int width, output int gap);
    wait_pin(act, 1200, rise);
    wait_pin(!act, 600, width);
    wait_pin(act, 600, gap);
  endtask : measure

  // Counts the cycles with the pin not low over a fixed span; never ends the run.
  task automatic count_high(input int lim, output int cnt);
    cnt = 0;
    repeat (lim)
    begin
      @(posedge clk_sys);
      if (pulse_output_pin !== 1'b0)
      begin
        cnt++;
      end
    end
  endtask : count_high

  always @(posedge clk_sys)
  begin
    rd_seen <= rd;
    if (rd_seen)
    begin
      check(rdata, exp_q.pop_front());
    end
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    reg_rd(`TMR_OFF_MODE, `TMR_MODE_RST);
    reg_rd(`TMR_OFF_CLKSEL, 8'h00);
    reg_rd(`TMR_OFF_CMP, `TMR_CMP_RST);
    reg_rd(`TMR_OFF_PORT, 8'h02);
    reg_rd(3'h5, 8'h00);
    check(pulse_output_pin_oe, 1'b0);
    reg_wr(`TMR_OFF_PORT, 8'h00);
    @(posedge clk_sys);
    check(pulse_output_pin_oe, 1'b1);
    reg_wr(`TMR_OFF_MODE, 8'h49);
    reg_rd(`TMR_OFF_MODE, 8'h41);
    reg_wr(`TMR_OFF_CMP, 8'h10);
    reg_wr(`TMR_OFF_MODE, 8'h40);
    reg_wr(`TMR_OFF_MODE, 8'hc0);
    count_high(600, k);
    check(k, 16'd0);
    reg_wr(`TMR_OFF_MODE, 8'h41);
    for (int i = 0; i < 4; i++)
    begin
      seed = xorshift(seed);
      n = (i == 0) ? 8'hff : (i == 1) ? 8'h01 : (seed[7:0] | 8'h02);
      pol = i[0];
      reg_wr(`TMR_OFF_CLKSEL, {7'h00, pol});
      reg_wr(`TMR_OFF_CMP, n);
      reg_wr(`TMR_OFF_MODE, {6'b010000, pol, 1'b1});
      repeat (2) @(posedge clk_sys);
      check(pulse_output_pin, pol);
      reg_wr(`TMR_OFF_MODE, {6'b110000, pol, 1'b1});
      measure(!pol, t0, w, g);
      check(t0 >= (256 << pol) - 8 && t0 <= (257 << pol) + 4, 1'b1);
      check(w, {8'h00, n} << pol);
      check(w + g, 16'd256 << pol);
      reg_wr(`TMR_OFF_MODE, {6'b010000, pol, 1'b1});
      repeat (2) @(posedge clk_sys);
      check(pulse_output_pin, pol);
      reg_rd(`TMR_OFF_CNT, 8'h00);
    end
    reg_wr(`TMR_OFF_CLKSEL, 8'h00);
    reg_wr(`TMR_OFF_CMP, 8'h00);
    reg_wr(`TMR_OFF_MODE, 8'hc1);
    count_high(600, k);
    check(k, 16'd0);
    reg_wr(`TMR_OFF_CMP, 8'h40);
    wait_pin(1'b1, 600, k);
    // The write lands in the cycle of the FFH count edge, which counts as after it.
    repeat (252) @(posedge clk_sys);
    reg_wr(`TMR_OFF_CMP, 8'h20);
    wait_pin(1'b0, 600, k);
    measure(1'b1, t0, w, g);
    check(w, 16'h0040);
    measure(1'b1, t0, w, g);
    check(w, 16'h0020);
    wait_pin(1'b0, 600, k);
    reg_wr(`TMR_OFF_CMP, 8'h60);
    reg_rd(`TMR_OFF_CMP, 8'h60);
    measure(1'b1, t0, w, g);
    check(w, 16'h0060);
    check(w + g, 16'd256);
    results();
  end
endmodule : test_eight_bit_timer_pwm_output
